// ==== dirs_pkg.sv ====
`default_nettype none
package dirs_pkg;
    // terminal function codes
    localparam logic [7:0] FUNC_SRC_SWITCH = 8'h02;
    localparam logic [7:0] FUNC_RAMP_HOLD = 8'h0A;
    localparam logic [7:0] FUNC_UP = 8'h10;
    localparam logic [7:0] FUNC_DOWN = 8'h11;
    localparam logic [7:0] FUNC_FWD_JOG = 8'h12;
    localparam logic [7:0] FUNC_REV_JOG = 8'h13;
    localparam logic [7:0] FUNC_TRIM_INC = 8'h1C;
    localparam logic [7:0] FUNC_TRIM_DEC = 8'h1D;
    localparam logic [7:0] FUNC_SAMPLE_HOLD = 8'h1E;
    // reference source codes
    localparam logic [3:0] REF_SRC_ANALOG_ONE = 4'h1;
    localparam logic [3:0] REF_SRC_ANALOG_TWO = 4'h2;
    localparam logic [3:0] SRC_OPTION_CARD = 4'h3;
    // timing, in milliseconds, counted on a one-millisecond tick
    localparam int TICK_PERIOD_MS = 1;
    localparam int SAMPLE_DELAY_MS = 100;
    localparam int JOG_CONFLICT_MS = 500;
    localparam int SAMPLE_DELAY_TICKS = SAMPLE_DELAY_MS / TICK_PERIOD_MS;
    localparam int JOG_CONFLICT_TICKS = JOG_CONFLICT_MS / TICK_PERIOD_MS;
    // reset value of the operation source, and the sample-hold state codes
    localparam logic SRC_LOCAL_RESET = 1'b1;
    localparam logic [2:0] SH_IDLE = 3'h1;
    localparam logic [2:0] SH_WAIT = 3'h2;
    localparam logic [2:0] SH_DONE = 3'h4;
    typedef enum logic [2:0] {
        SH_ST_IDLE = SH_IDLE,
        SH_ST_WAIT = SH_WAIT,
        SH_ST_DONE = SH_DONE
    } sh_state_t;
endpackage
`default_nettype wire

// ==== ms_interval_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ms_interval_timer #(
    parameter int LIMIT = 100
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ms_tick,
    input wire logic enable,
    output logic reached
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    always_comb begin
        next_count = count;
        if (!enable) begin
            next_count = '0;
        end else if (ms_tick && count < LIMIT_C) begin
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign reached = (count == LIMIT_C);

    AST_TIMER_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
        !enable |=> count == '0) else $error("interval counter not cleared");
    AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!arst_n)
        enable && ms_tick && !reached |=> count == $past(count) + CW'(1))
        else $error("interval counter did not advance on tick");
endmodule
`default_nettype wire

// ==== digital_input_reference_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module digital_input_reference_select import dirs_pkg::*; #(
    parameter int FREQ_W = 16,
    parameter int TERM_N = 5
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ms_tick,
    input wire logic [TERM_N-1:0] input_terminal,
    input wire logic [TERM_N-1:0][7:0] input_function_select,
    input wire logic [3:0] reference_source_select,
    input wire logic [3:0] run_source_select,
    input wire logic [1:0] stopping_method_select,
    input wire logic [FREQ_W-1:0] analog_input_one,
    input wire logic [FREQ_W-1:0] analog_input_two,
    input wire logic [FREQ_W-1:0] panel_freq_ref,
    input wire logic [FREQ_W-1:0] option_freq_ref,
    input wire logic local_run_cmd,
    input wire logic option_run_cmd,
    input wire logic [FREQ_W-1:0] trim_step_amount,
    input wire logic [FREQ_W-1:0] jog_frequency_setting,
    output logic [FREQ_W-1:0] freq_ref,
    output logic run_cmd,
    output logic run_reverse,
    output logic jog_active,
    output logic stop_request,
    output logic [1:0] stop_method,
    output logic source_is_local,
    output logic held_valid,
    output logic invalid_input_select_alarm
);
    localparam logic [FREQ_W-1:0] FREQ_MAX = '1;

    function automatic logic func_assigned(input logic [TERM_N-1:0][7:0] sel,
                                           input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < TERM_N; i++) begin
            hit = hit | (sel[i] == code);
        end
        return hit;
    endfunction

    function automatic logic func_on(input logic [TERM_N-1:0][7:0] sel,
                                     input logic [TERM_N-1:0] term,
                                     input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < TERM_N; i++) begin
            hit = hit | ((sel[i] == code) & term[i]);
        end
        return hit;
    endfunction

    logic inc_asg, dec_asg, sh_asg, src_asg, other_asg;
    logic inc_on, dec_on, sh_on, src_on, forward_jog_cmd_on, reverse_jog_cmd_on;
    logic alarm_now, base_is_analog, trim_ok;
    logic [FREQ_W-1:0] local_ref, sel_ref, analog_sample, trim_ref;
    logic [FREQ_W:0] trim_sum;
    logic run_sel, sh_reached, conflict_reached, any_jog;

    assign inc_asg = func_assigned(input_function_select, FUNC_TRIM_INC);
    assign dec_asg = func_assigned(input_function_select, FUNC_TRIM_DEC);
    assign sh_asg = func_assigned(input_function_select, FUNC_SAMPLE_HOLD);
    assign src_asg = func_assigned(input_function_select, FUNC_SRC_SWITCH);
    assign other_asg = func_assigned(input_function_select, FUNC_RAMP_HOLD)
        | func_assigned(input_function_select, FUNC_UP)
        | func_assigned(input_function_select, FUNC_DOWN)
        | inc_asg | dec_asg;
    assign inc_on = func_on(input_function_select, input_terminal, FUNC_TRIM_INC);
    assign dec_on = func_on(input_function_select, input_terminal, FUNC_TRIM_DEC);
    assign sh_on = func_on(input_function_select, input_terminal, FUNC_SAMPLE_HOLD);
    assign src_on = func_on(input_function_select, input_terminal, FUNC_SRC_SWITCH);
    assign forward_jog_cmd_on = func_on(input_function_select, input_terminal, FUNC_FWD_JOG);
    assign reverse_jog_cmd_on = func_on(input_function_select, input_terminal, FUNC_REV_JOG);
    assign any_jog = forward_jog_cmd_on | reverse_jog_cmd_on;

    assign alarm_now = (inc_asg ^ dec_asg)
        | (sh_asg & other_asg);

    // local reference per the source selection
    always_comb begin
        base_is_analog = 1'b1;
        case (reference_source_select)
            REF_SRC_ANALOG_ONE: local_ref = analog_input_one;
            REF_SRC_ANALOG_TWO: local_ref = analog_input_two;
            default: begin
                local_ref = panel_freq_ref;
                base_is_analog = 1'b0;
            end
        endcase
    end
    assign analog_sample = (reference_source_select == REF_SRC_ANALOG_TWO) ?
        analog_input_two : analog_input_one;

    // ---- operation source switching
    logic src_local, next_src_local;
    logic switch_ok;
    // switching only makes sense while neither local selection names the option card
    assign switch_ok = src_asg && (reference_source_select != SRC_OPTION_CARD)
        && (run_source_select != SRC_OPTION_CARD);
    always_comb begin
        next_src_local = src_local;
        if (!run_cmd) begin
            next_src_local = switch_ok ? src_on : 1'b1;
        end
    end
    assign sel_ref = src_local ? local_ref : option_freq_ref;
    assign run_sel = src_local ? local_run_cmd : option_run_cmd;

    // ---- trim
    assign trim_ok = inc_asg & dec_asg & !alarm_now & src_local & base_is_analog
        & (sel_ref != '0);
    assign trim_sum = {1'b0, sel_ref} + {1'b0, trim_step_amount};
    always_comb begin
        trim_ref = sel_ref;
        if (trim_ok && inc_on && !dec_on) begin
            trim_ref = trim_sum[FREQ_W] ? FREQ_MAX : trim_sum[FREQ_W-1:0];
        end else if (trim_ok && dec_on && !inc_on) begin
            trim_ref = (sel_ref < trim_step_amount) ? '0
                : sel_ref - trim_step_amount;
        end
    end

    // ---- sample and hold
    sh_state_t sh_state, next_sh_state;
    logic [FREQ_W-1:0] held_ref, next_held_ref;
    logic next_held_valid;
    logic sh_en;
    assign sh_en = sh_asg & sh_on & !alarm_now;

    ms_interval_timer #(
        .LIMIT(SAMPLE_DELAY_TICKS)
    ) sample_timer (
        .clk(clk),
        .arst_n(arst_n),
        .ms_tick(ms_tick),
        .enable(sh_en),
        .reached(sh_reached)
    );

    always_comb begin
        next_sh_state = sh_state;
        next_held_ref = held_ref;
        next_held_valid = held_valid & sh_asg & !alarm_now;
        case (sh_state)
            SH_ST_IDLE: begin
                if (sh_en) begin
                    next_sh_state = SH_ST_WAIT;
                end
            end
            SH_ST_WAIT: begin
                if (!sh_en) begin
                    next_sh_state = SH_ST_IDLE;
                end else if (sh_reached) begin
                    next_held_ref = analog_sample;
                    next_held_valid = 1'b1;
                    next_sh_state = SH_ST_DONE;
                end
            end
            SH_ST_DONE: begin
                if (!sh_en) begin
                    next_sh_state = SH_ST_IDLE;
                end
            end
            default: next_sh_state = SH_ST_IDLE;
        endcase
    end

    // ---- jog
    logic jog_stop, next_jog_stop, next_reverse, next_run, next_jog_active;
    logic [FREQ_W-1:0] next_freq;

    ms_interval_timer #(
        .LIMIT(JOG_CONFLICT_TICKS)
    ) jog_conflict_timer (
        .clk(clk),
        .arst_n(arst_n),
        .ms_tick(ms_tick),
        .enable(forward_jog_cmd_on & reverse_jog_cmd_on),
        .reached(conflict_reached)
    );

    always_comb begin
        next_jog_stop = any_jog & (jog_stop | (conflict_reached & forward_jog_cmd_on & reverse_jog_cmd_on));
        next_jog_active = any_jog & !next_jog_stop;
        next_run = next_jog_active | (run_sel & !next_jog_stop);
        next_reverse = 1'b0;
        if (next_jog_active) begin
            next_reverse = (forward_jog_cmd_on & reverse_jog_cmd_on) ? run_reverse : reverse_jog_cmd_on;
        end
        if (next_jog_active) begin
            next_freq = jog_frequency_setting;
        end else if (held_valid) begin
            next_freq = held_ref;
        end else begin
            next_freq = trim_ref;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_local <= SRC_LOCAL_RESET;
            sh_state <= SH_ST_IDLE;
            held_ref <= '0;
            held_valid <= 1'b0;
            jog_stop <= 1'b0;
            freq_ref <= '0;
            run_cmd <= 1'b0;
            run_reverse <= 1'b0;
            jog_active <= 1'b0;
            invalid_input_select_alarm <= 1'b0;
        end else begin
            src_local <= next_src_local;
            sh_state <= next_sh_state;
            held_ref <= next_held_ref;
            held_valid <= next_held_valid;
            jog_stop <= next_jog_stop;
            freq_ref <= next_freq;
            run_cmd <= next_run;
            run_reverse <= next_reverse;
            jog_active <= next_jog_active;
            invalid_input_select_alarm <= alarm_now;
        end
    end

    assign stop_request = jog_stop;
    assign stop_method = stopping_method_select;
    assign source_is_local = src_local;

    AST_JOG_FREQ: assert property (@(posedge clk) disable iff (!arst_n)
        next_jog_active |=> jog_active && freq_ref == $past(jog_frequency_setting))
        else $error("jog frequency not taken");
    AST_TRIM_CLAMP: assert property (@(posedge clk) disable iff (!arst_n)
        trim_ok && dec_on && !inc_on && sel_ref < trim_step_amount && !any_jog
        && !held_valid |=> freq_ref == '0) else $error("trim not clamped to zero");
    AST_TRIM_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        !trim_ok && !any_jog && !held_valid |=> freq_ref == $past(sel_ref))
        else $error("trim applied while disabled");
    AST_ALARM_PAIR: assert property (@(posedge clk) disable iff (!arst_n)
        inc_asg != dec_asg |=> invalid_input_select_alarm)
        else $error("lone trim function not flagged");
    AST_ALARM_SH: assert property (@(posedge clk) disable iff (!arst_n)
        sh_asg && other_asg |=> invalid_input_select_alarm)
        else $error("sample-hold conflict not flagged");
    AST_SH_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
        sh_state == SH_ST_WAIT && sh_en && sh_reached
        |=> held_valid && held_ref == $past(analog_sample))
        else $error("sample not captured at delay");
    AST_SH_EARLY: assert property (@(posedge clk) disable iff (!arst_n)
        sh_state == SH_ST_WAIT && !sh_en |=> sh_state == SH_ST_IDLE
        && held_ref == $past(held_ref)) else $error("early release captured");
    AST_SRC_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
        run_cmd |=> src_local == $past(src_local))
        else $error("source changed while running");
    AST_JOG_RUN: assert property (@(posedge clk) disable iff (!arst_n)
        (forward_jog_cmd_on ^ reverse_jog_cmd_on) && !jog_stop |=> run_cmd && run_reverse == $past(reverse_jog_cmd_on))
        else $error("jog did not run in its direction");
    AST_CONFLICT_STOP: assert property (@(posedge clk) disable iff (!arst_n)
        forward_jog_cmd_on && reverse_jog_cmd_on && conflict_reached |=> stop_request && !run_cmd)
        else $error("jog conflict did not stop");

    COV_SH_HOLD: cover property (@(posedge clk) disable iff (!arst_n)
        sh_state == SH_ST_WAIT ##1 held_valid);
    COV_JOG_STOP: cover property (@(posedge clk) disable iff (!arst_n)
        !stop_request ##1 stop_request);
    COV_SRC_SWITCH: cover property (@(posedge clk) disable iff (!arst_n)
        src_local ##1 !src_local);
    COV_TRIM_UP: cover property (@(posedge clk) disable iff (!arst_n)
        trim_ok && inc_on && !dec_on);
endmodule
`default_nettype wire

// ==== terminal_switches.sv ====
`timescale 1ns/100ps
`default_nettype none
module terminal_switches #(
    parameter int N = 5
) (
    input wire logic clk,
    output logic [N-1:0] level
);
    initial level = '0;

    // contacts only move just after a falling edge, clear of the sampling edge
    task automatic set_contact(input int idx, input logic on);
        @(negedge clk);
        level[idx] = on;
    endtask

    // one closure of a contact for a number of cycles, then opened again
    task automatic press(input int idx, input int cycles);
        set_contact(idx, 1'b1);
        repeat (cycles) @(negedge clk);
        level[idx] = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dirs_pkg::*;
    logic clk, arst_n, ms_tick, local_run, opt_run, run_cmd, run_reverse, jog_active;
    logic stop_request, source_is_local, held_valid, alarm;
    logic [4:0] term;
    logic [4:0][7:0] fsel;
    logic [3:0] ref_sel, run_sel;
    logic [1:0] stop_sel, stop_method;
    logic [15:0] a1, a2, panel, opt, step, jogf, freq_ref;
    int err_count = 0;
    int checks = 0;

    terminal_switches u_terminal_switches (.clk(clk), .level(term));

    digital_input_reference_select u_digital_input_reference_select (
        .clk(clk), .arst_n(arst_n), .ms_tick(ms_tick), .input_terminal(term),
        .input_function_select(fsel), .reference_source_select(ref_sel),
        .run_source_select(run_sel), .stopping_method_select(stop_sel),
        .analog_input_one(a1), .analog_input_two(a2), .panel_freq_ref(panel),
        .option_freq_ref(opt), .local_run_cmd(local_run), .option_run_cmd(opt_run),
        .trim_step_amount(step), .jog_frequency_setting(jogf), .freq_ref(freq_ref),
        .run_cmd(run_cmd), .run_reverse(run_reverse), .jog_active(jog_active),
        .stop_request(stop_request), .stop_method(stop_method),
        .source_is_local(source_is_local), .held_valid(held_valid),
        .invalid_input_select_alarm(alarm)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // millisecond tick shortened to one pulse every second cycle
    initial ms_tick = 1'b0;
    always @(negedge clk) begin
        ms_tick <= ~ms_tick;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        settle(2);
        check(held_valid, 1'b0);
        check(source_is_local, 1'b1);
        arst_n = 1'b1;
    endtask

    task automatic trim_case(input logic inc, input logic dec, input logic [15:0] exp);
        u_terminal_switches.set_contact(0, inc);
        u_terminal_switches.set_contact(1, dec);
        settle(3);
        check(freq_ref, exp);
    endtask

    task automatic test_trim();
        local_run = 1'b1;
        trim_case(1'b0, 1'b0, 16'h0032);
        trim_case(1'b1, 1'b0, 16'h003C);
        trim_case(1'b0, 1'b1, 16'h0028);
        trim_case(1'b1, 1'b1, 16'h0032);
        a1 = 16'h0005;
        trim_case(1'b0, 1'b1, 16'h0000);
        a1 = 16'h0000;
        trim_case(1'b1, 1'b0, 16'h0000);
        a1 = 16'h0032;
        ref_sel = 4'h0;
        trim_case(1'b1, 1'b0, 16'h0777);
        ref_sel = REF_SRC_ANALOG_TWO;
        trim_case(1'b1, 1'b0, 16'h044E);
        ref_sel = REF_SRC_ANALOG_ONE;
        trim_case(1'b0, 1'b0, 16'h0032);
    endtask

    task automatic test_jog();
        local_run = 1'b0;
        u_terminal_switches.set_contact(3, 1'b1);
        settle(3);
        check({run_cmd, run_reverse, jog_active}, 3'b101);
        check(freq_ref, 16'h0123);
        u_terminal_switches.set_contact(3, 1'b0);
        u_terminal_switches.set_contact(4, 1'b1);
        settle(3);
        check({run_cmd, run_reverse, freq_ref}, {2'b11, 16'h0123});
        u_terminal_switches.set_contact(3, 1'b1);
        settle(800);
        check({stop_request, run_cmd}, 2'b01);
        settle(300);
        check({stop_request, run_cmd, stop_method}, {2'b10, 2'h2});
        u_terminal_switches.set_contact(3, 1'b0);
        u_terminal_switches.set_contact(4, 1'b0);
        settle(3);
        check(stop_request, 1'b0);
    endtask

    task automatic test_source();
        local_run = 1'b1;
        settle(3);
        u_terminal_switches.set_contact(2, 1'b0);
        settle(6);
        check(source_is_local, 1'b1);
        opt_run = 1'b1;
        local_run = 1'b0;
        settle(6);
        check({source_is_local, run_cmd, freq_ref}, {2'b01, 16'h0999});
        u_terminal_switches.set_contact(2, 1'b1);
        settle(6);
        check(source_is_local, 1'b0);
        opt_run = 1'b0;
        settle(6);
        check({source_is_local, freq_ref}, {1'b1, 16'h0032});
    endtask

    task automatic test_alarm();
        logic [7:0] codes [5] = '{8'h0A, 8'h10, 8'h11, 8'h1C, 8'h1D};
        fsel[1] = 8'h00;
        settle(3);
        check(alarm, 1'b1);
        fsel[0] = FUNC_SAMPLE_HOLD;
        foreach (codes[i]) begin
            fsel[1] = codes[i];
            settle(3);
            check(alarm, 1'b1);
        end
        fsel[1] = 8'h00;
        settle(3);
        check(alarm, 1'b0);
    endtask

    task automatic test_hold();
        a1 = 16'h0200;
        u_terminal_switches.press(0, 80);
        a1 = 16'h0300;
        settle(3);
        check({held_valid, freq_ref}, {1'b0, 16'h0300});
        a1 = 16'h0200;
        fork
            u_terminal_switches.press(0, 230);
            begin
                settle(180);
                check(held_valid, 1'b0);
                settle(35);
                check(held_valid, 1'b1);
            end
        join
        a1 = 16'h0300;
        settle(3);
        check(freq_ref, 16'h0200);
        do_reset();
        settle(3);
        check({held_valid, freq_ref}, {1'b0, 16'h0300});
    endtask

    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        arst_n = 1'b0;
        fsel = {FUNC_REV_JOG, FUNC_FWD_JOG, FUNC_SRC_SWITCH, FUNC_TRIM_DEC, FUNC_TRIM_INC};
        ref_sel = REF_SRC_ANALOG_ONE;
        run_sel = 4'h1;
        stop_sel = 2'h2;
        a1 = 16'h0032;
        a2 = 16'h0444;
        panel = 16'h0777;
        opt = 16'h0999;
        step = 16'h000A;
        jogf = 16'h0123;
        local_run = 1'b0;
        opt_run = 1'b0;
        u_terminal_switches.set_contact(2, 1'b1);
        settle(2);
        check({held_valid, freq_ref, source_is_local}, {17'h0, 1'b1});
        arst_n = 1'b1;
        test_trim();
        test_jog();
        test_source();
        test_alarm();
        test_hold();
        conclude();
    end
endmodule
`default_nettype wire
